// File: core/ccdo_core.sv
// execution of watchdog clear, call via accumulator, complement, clears
// and decrements for an 8-bit core
`timescale 1ns/100ps
module ccdo_core
    import ccdo_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       reset_n_in,
    input  wire logic                       op_valid_in,
    input  wire logic [ccdo_pkg::INSTR_W-1:0] instr_in,
    input  wire logic [ccdo_pkg::DATA_W-1:0]  reg_data_in,
    input  wire logic [ccdo_pkg::DATA_W-1:0]  accum_in,
    input  wire logic [ccdo_pkg::PC_W-1:0]    pc_in,
    input  wire logic [ccdo_pkg::LATCH_W-1:0] counter_latch_in,
    output logic                            op_ready_out,
    output logic                            reg_we_out,
    output logic [ccdo_pkg::ADDR_W-1:0]     reg_addr_out,
    output logic                            acc_we_out,
    output logic [ccdo_pkg::DATA_W-1:0]     wr_data_out,
    output logic                            zero_we_out,
    output logic                            zero_val_out,
    output logic                            watchdog_clear_out,
    output logic                            expiry_flag_set_out,
    output logic                            sleep_entry_flag_set_out,
    output logic                            stack_push_out,
    output logic [ccdo_pkg::PC_W-1:0]       stack_head_out,
    output logic                            pc_load_out,
    output logic [ccdo_pkg::PC_W-1:0]       pc_load_val_out,
    output logic                            skip_next_out
);
    import ccdo_pkg::*;

    ccdo_alu_if alu_bus ();

    ccdo_alu u_alu (
        .alu_io (alu_bus.alu)
    );

    ccdo_state_t       state_q;
    ccdo_state_t       state_d;
    logic              ready_q;
    logic              reg_we_q;
    logic [ADDR_W-1:0] reg_addr_q;
    logic              acc_we_q;
    logic [DATA_W-1:0] wr_data_q;
    logic              zero_we_q;
    logic              zero_val_q;
    logic              wd_clr_q;
    logic              push_q;
    logic [PC_W-1:0]   head_q;
    logic              pc_load_q;
    logic [PC_W-1:0]   pc_val_q;
    logic [PC_W-1:0]   pc_val_d;
    logic              skip_q;

    // decode
    wire       take      = op_valid_in && ready_q;
    wire ccdo_op_t op_sel = ccdo_op_t'(instr_in[OPSEL_MSB:OPSEL_LSB]);
    wire       dest_bit  = instr_in[DEST_POS];
    wire [ADDR_W-1:0] addr_fld = instr_in[ADDR_MSB:ADDR_LSB];
    wire       do_call   = take && (op_sel == OP_ACALL);
    wire       do_wdclr  = take && (op_sel == OP_WDCLR);
    wire       do_dsz    = take && (op_sel == OP_DECSZ);
    wire       do_skip   = do_dsz && alu_bus.zero;
    wire [PC_W-1:0] ret_addr = PC_W'(pc_in + PC_STEP);
    wire [PC_W-1:0] call_tgt = {counter_latch_in, accum_in};

    assign alu_bus.op      = take ? op_sel : OP_NONE;
    assign alu_bus.dest    = dest_bit;
    assign alu_bus.operand = reg_data_in;

    // sequencer: only the call and a taken skip hold off the next op
    always_comb
    begin
        state_d = ST_IDLE;
        unique case (state_q)
            ST_IDLE:
            begin
                if (do_call)
                    state_d = ST_CALL;
                else if (do_skip)
                    state_d = ST_SKIP;
                else
                    state_d = ST_IDLE;
            end
            ST_CALL: state_d = ST_IDLE;
            ST_SKIP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // call target is caught at issue and driven out one cycle later
    assign pc_val_d = do_call ? call_tgt : pc_val_q;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q   <= ST_IDLE;
            ready_q   <= 1'b0;
            pc_val_q  <= PC_RESET;
            pc_load_q <= 1'b0;
            skip_q    <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            ready_q   <= (state_d == ST_IDLE);
            pc_val_q  <= pc_val_d;
            pc_load_q <= (state_q == ST_CALL);
            skip_q    <= do_skip;
        end
    end

    // write-back from the data path; status only where it is allowed
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            reg_we_q   <= 1'b0;
            reg_addr_q <= ADDR_RESET;
            acc_we_q   <= 1'b0;
            wr_data_q  <= ZERO_BYTE;
            zero_we_q  <= 1'b0;
            zero_val_q <= 1'b0;
        end
        else
        begin
            reg_we_q   <= alu_bus.to_reg;
            reg_addr_q <= addr_fld;
            acc_we_q   <= alu_bus.to_acc;
            wr_data_q  <= alu_bus.result;
            zero_we_q  <= alu_bus.zero_we;
            zero_val_q <= alu_bus.zero;
        end
    end

    // side effects toward the watchdog and the return stack
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wd_clr_q <= 1'b0;
            push_q   <= 1'b0;
            head_q   <= PC_RESET;
        end
        else
        begin
            wd_clr_q <= do_wdclr;
            push_q   <= do_call;
            head_q   <= do_call ? ret_addr : head_q;
        end
    end

    assign op_ready_out             = ready_q;
    assign reg_we_out               = reg_we_q;
    assign reg_addr_out             = reg_addr_q;
    assign acc_we_out               = acc_we_q;
    assign wr_data_out              = wr_data_q;
    assign zero_we_out              = zero_we_q;
    assign zero_val_out             = zero_val_q;
    // one pulse clears counter and prescaler together and sets both flags
    assign watchdog_clear_out       = wd_clr_q;
    assign expiry_flag_set_out      = wd_clr_q;
    assign sleep_entry_flag_set_out = wd_clr_q;
    assign stack_push_out           = push_q;
    assign stack_head_out           = head_q;
    assign pc_load_out              = pc_load_q;
    assign pc_load_val_out          = pc_val_q;
    assign skip_next_out            = skip_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    wire take_inv     = take && (op_sel == OP_INVERT);
    wire take_clr_reg = take && (op_sel == OP_CLRREG);
    wire take_clr_acc = take && (op_sel == OP_CLRACC);
    wire take_dec     = take && (op_sel == OP_DEC);

    sequence call_issue_s;
        do_call;
    endsequence
    sequence call_push_s;
        stack_push_out && !pc_load_out && !op_ready_out;
    endsequence
    sequence call_load_s;
        pc_load_out && !stack_push_out && op_ready_out;
    endsequence

    wdog_pulse_a: assert property (
        do_wdclr |=> watchdog_clear_out && expiry_flag_set_out
                     && sleep_entry_flag_set_out
                     ##1 (watchdog_clear_out == $past(do_wdclr)))
        else $error("watchdog clear pulse wrong");

    call_push_first_a: assert property (
        call_issue_s |=> call_push_s
                         and (stack_head_out == $past(pc_in) + PC_STEP))
        else $error("call did not push return address first");

    call_target_a: assert property (
        do_call ##1 1'b1 |=> call_load_s and
            (pc_load_val_out == {$past(counter_latch_in, 2),
                                 $past(accum_in, 2)}))
        else $error("call target not built from latch and accumulator");

    call_two_cycle_a: assert property (
        call_issue_s |=> (!zero_we_out)[*2] ##0 op_ready_out)
        else $error("call length or status effect wrong");

    invert_write_a: assert property (
        take_inv |=> wr_data_out == ~$past(reg_data_in) && zero_we_out
            && (reg_we_out == $past(dest_bit))
            && (acc_we_out != $past(dest_bit)))
        else $error("complement result or destination wrong");

    clr_reg_zero_a: assert property (
        take_clr_reg |=> reg_we_out && !acc_we_out
                      && wr_data_out == ZERO_BYTE
                      && zero_we_out && zero_val_out)
        else $error("clear register wrong");

    clr_acc_zero_a: assert property (
        take_clr_acc |=> acc_we_out && !reg_we_out
                      && wr_data_out == ZERO_BYTE
                      && zero_we_out && zero_val_out)
        else $error("clear accumulator wrong");

    dec_write_a: assert property (
        take_dec |=> wr_data_out == $past(reg_data_in) - ONE_BYTE
            && zero_we_out && (reg_we_out == $past(dest_bit)))
        else $error("decrement result or destination wrong");

    dsz_no_flag_a: assert property (
        do_dsz |=> !zero_we_out && (acc_we_out != $past(dest_bit))
            && wr_data_out == $past(reg_data_in) - ONE_BYTE)
        else $error("decrement-skip touched status or misrouted");

    dsz_skip_len_a: assert property (
        do_dsz |=> (skip_next_out == (wr_data_out == ZERO_BYTE))
            && (op_ready_out != skip_next_out)
            ##1 (op_ready_out || !$past(skip_next_out)))
        else $error("skip decision or length wrong");

    zero_flag_val_a: assert property (
        zero_we_out |-> zero_val_out == (wr_data_out == ZERO_BYTE))
        else $error("zero flag disagrees with result");

    reg_addr_fld_a: assert property (
        reg_we_out |-> reg_addr_out == $past(instr_in[ADDR_MSB:ADDR_LSB]))
        else $error("register address not the 7-bit field");

    // write, stall, hold and ordering checks, each spanning at most two cycles
    wdog_no_write_a: assert property (
        do_wdclr |=> !reg_we_out && !acc_we_out && !zero_we_out)
        else $error("watchdog clear wrote data or status");

    stall_refuse_a: assert property (
        !op_ready_out && op_valid_in |=> !reg_we_out && !acc_we_out
            && !zero_we_out && !stack_push_out && !skip_next_out)
        else $error("word taken while stalled");

    single_push_a: assert property (
        stack_push_out |=> !stack_push_out)
        else $error("call pushed more than once");

    push_before_load_a: assert property (
        pc_load_out |-> $past(stack_push_out) && !stack_push_out)
        else $error("counter reloaded without a push first");

    head_hold_a: assert property (
        !do_call |=> $stable(stack_head_out))
        else $error("return address moved without a call");

    target_hold_a: assert property (
        !do_call |=> $stable(pc_load_val_out))
        else $error("call target moved without a call");

    simple_ready_a: assert property (
        take && !do_call && !do_skip |=> op_ready_out)
        else $error("single-cycle op stalled the next word");

    skip_source_a: assert property (
        skip_next_out |-> $past(do_dsz) && wr_data_out == ZERO_BYTE)
        else $error("skip without a zero decrement-skip result");

    dsz_route_a: assert property (
        do_dsz |=> reg_we_out == $past(dest_bit))
        else $error("decrement-skip result misrouted");
endmodule

// File: core/ccdo_pkg.sv
// constants and types shared by the clear/call/decrement execution block
package ccdo_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int LATCH_W = 7;
    localparam int ADDR_W = 7;
    localparam int INSTR_W = 14;
    // instruction word layout: operation select, destination bit, address
    localparam int OPSEL_MSB = 13;
    localparam int OPSEL_LSB = 11;
    localparam int DEST_POS = 7;
    localparam int ADDR_MSB = 6;
    localparam int ADDR_LSB = 0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam int CALL_CYCLES = 2;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_WDCLR  = 3'h1,
        OP_ACALL  = 3'h2,
        OP_INVERT = 3'h3,
        OP_CLRREG = 3'h4,
        OP_CLRACC = 3'h5,
        OP_DEC    = 3'h6,
        OP_DECSZ  = 3'h7
    } ccdo_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CALL = 2'h1,
        ST_SKIP = 2'h2
    } ccdo_state_t;
endpackage

// File: core/ccdo_alu_if.sv
// carrier between the sequencer and the data path of the block
`timescale 1ns/100ps
interface ccdo_alu_if;
    import ccdo_pkg::*;
    ccdo_op_t          op;
    logic              dest;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic              zero;
    logic              to_acc;
    logic              to_reg;
    logic              zero_we;

    modport seq (output op, dest, operand,
                 input result, zero, to_acc, to_reg, zero_we);
    modport alu (input op, dest, operand,
                 output result, zero, to_acc, to_reg, zero_we);
endinterface

// File: core/ccdo_alu.sv
// data path: result, destination select and zero flag for one operation
`timescale 1ns/100ps
module ccdo_alu
    import ccdo_pkg::*;
(
    ccdo_alu_if.alu    alu_io
);
    wire is_inv     = (alu_io.op == OP_INVERT);
    wire is_clr_reg = (alu_io.op == OP_CLRREG);
    wire is_clr_acc = (alu_io.op == OP_CLRACC);
    wire is_dec     = (alu_io.op == OP_DEC) || (alu_io.op == OP_DECSZ);
    wire routed     = is_inv || is_dec;

    wire [DATA_W-1:0] dec_val = DATA_W'(alu_io.operand - ONE_BYTE);

    assign alu_io.result = is_inv  ? ~alu_io.operand :
                           is_dec  ? dec_val :
                           ZERO_BYTE;
    assign alu_io.zero = (alu_io.result == ZERO_BYTE);
    // skip variant never touches status
    assign alu_io.zero_we = is_inv || is_clr_reg || is_clr_acc ||
                            (alu_io.op == OP_DEC);
    assign alu_io.to_reg = is_clr_reg || (routed && alu_io.dest);
    assign alu_io.to_acc = is_clr_acc || (routed && !alu_io.dest);
endmodule

// File: verif/cpu_clear_call_decrement_ops_bench.sv
// self-checking bench for the clear/call/decrement execution block
`timescale 1ns/100ps
module cpu_clear_call_decrement_ops_bench;
    import ccdo_pkg::*;
    logic                 clk_in;
    logic                 reset_n_in;
    logic                 op_valid_in;
    logic [INSTR_W-1:0]   instr_in;
    logic [DATA_W-1:0]    reg_data_in;
    logic [DATA_W-1:0]    accum_in;
    logic [PC_W-1:0]      pc_in;
    logic [LATCH_W-1:0]   counter_latch_in;
    logic                 op_ready_out;
    logic                 reg_we_out;
    logic [ADDR_W-1:0]    reg_addr_out;
    logic                 acc_we_out;
    logic [DATA_W-1:0]    wr_data_out;
    logic                 zero_we_out;
    logic                 zero_val_out;
    logic                 watchdog_clear_out;
    logic                 expiry_flag_set_out;
    logic                 sleep_entry_flag_set_out;
    logic                 stack_push_out;
    logic [PC_W-1:0]      stack_head_out;
    logic                 pc_load_out;
    logic [PC_W-1:0]      pc_load_val_out;
    logic                 skip_next_out;
    int                   failures;
    int                   n_compared;
    int                   cycles;

    ccdo_core dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .op_valid_in(op_valid_in), .instr_in(instr_in),
        .reg_data_in(reg_data_in), .accum_in(accum_in), .pc_in(pc_in),
        .counter_latch_in(counter_latch_in), .op_ready_out(op_ready_out),
        .reg_we_out(reg_we_out), .reg_addr_out(reg_addr_out),
        .acc_we_out(acc_we_out), .wr_data_out(wr_data_out),
        .zero_we_out(zero_we_out), .zero_val_out(zero_val_out),
        .watchdog_clear_out(watchdog_clear_out),
        .expiry_flag_set_out(expiry_flag_set_out),
        .sleep_entry_flag_set_out(sleep_entry_flag_set_out),
        .stack_push_out(stack_push_out), .stack_head_out(stack_head_out),
        .pc_load_out(pc_load_out), .pc_load_val_out(pc_load_val_out),
        .skip_next_out(skip_next_out));

    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // whole run is a few dozen cycles; the ceiling only catches a hang
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask

    // presents one word while ready; valid stays up until settle()
    task automatic issue(input ccdo_op_t op, input logic d,
                         input logic [6:0] a, input logic [7:0] r);
        chk("op_ready", 16'h0001, {15'h0, op_ready_out});
        instr_in = {op, 3'h0, d, a};
        reg_data_in = r;
        op_valid_in = 1'b1;
        step();
    endtask

    // drops the request and lets one edge pass before the next word
    task automatic settle();
        op_valid_in = 1'b0;
        step();
    endtask

    task automatic chk_wr(input logic rwe, input logic awe,
                          input logic [7:0] data, input logic zwe,
                          input logic zval, input logic skp);
        chk("reg_we", {15'h0, rwe}, {15'h0, reg_we_out});
        chk("acc_we", {15'h0, awe}, {15'h0, acc_we_out});
        chk("zero_we", {15'h0, zwe}, {15'h0, zero_we_out});
        chk("skip_next", {15'h0, skp}, {15'h0, skip_next_out});
        chk("wd_clear", 16'h0000, {15'h0, watchdog_clear_out});
        chk("push", 16'h0000, {15'h0, stack_push_out});
        if (rwe | awe)
            chk("wr_data", {8'h0, data}, {8'h0, wr_data_out});
        if (zwe)
            chk("zero_val", {15'h0, zval}, {15'h0, zero_val_out});
    endtask

    task automatic t_wdclr();
        issue(OP_WDCLR, 1'b0, 7'h00, 8'h00);
        chk("wd_clear", 16'h0001, {15'h0, watchdog_clear_out});
        chk("expiry", 16'h0001, {15'h0, expiry_flag_set_out});
        chk("sleep", 16'h0001, {15'h0, sleep_entry_flag_set_out});
        chk("zero_we", 16'h0000, {15'h0, zero_we_out});
        settle();
        chk("wd_clear", 16'h0000, {15'h0, watchdog_clear_out});
    endtask

    task automatic t_call();
        pc_in = 15'h7ffe;
        counter_latch_in = 7'h5a;
        accum_in = 8'hc3;
        issue(OP_ACALL, 1'b0, 7'h00, 8'h00);
        chk("push", 16'h0001, {15'h0, stack_push_out});
        chk("head", 16'h7fff, {1'b0, stack_head_out});
        chk("pc_load", 16'h0000, {15'h0, pc_load_out});
        chk("op_ready", 16'h0000, {15'h0, op_ready_out});
        chk("zero_we", 16'h0000, {15'h0, zero_we_out});
        // a word offered while stalled must not be taken
        instr_in = {OP_CLRACC, 3'h0, 1'b0, 7'h00};
        op_valid_in = 1'b1;
        step();
        op_valid_in = 1'b0;
        chk("acc_we", 16'h0000, {15'h0, acc_we_out});
        chk("pc_load", 16'h0001, {15'h0, pc_load_out});
        chk("pc_val", 16'h5ac3, {1'b0, pc_load_val_out});
        chk("zero_we", 16'h0000, {15'h0, zero_we_out});
        chk("op_ready", 16'h0001, {15'h0, op_ready_out});
        step();
        chk("acc_we", 16'h0000, {15'h0, acc_we_out});
    endtask

    task automatic t_complement_register_op();
        issue(OP_INVERT, 1'b0, 7'h7f, 8'h5a);
        chk_wr(1'b0, 1'b1, 8'ha5, 1'b1, 1'b0, 1'b0);
        issue(OP_INVERT, 1'b1, 7'h7f, 8'hff);
        chk_wr(1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0);
        chk("reg_addr", 16'h007f, {9'h0, reg_addr_out});
        settle();
    endtask

    task automatic t_clear();
        issue(OP_CLRREG, 1'b0, 7'h23, 8'h77);
        chk_wr(1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0);
        chk("reg_addr", 16'h0023, {9'h0, reg_addr_out});
        issue(OP_CLRACC, 1'b1, 7'h00, 8'h77);
        chk_wr(1'b0, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
        issue(OP_NONE, 1'b1, 7'h00, 8'h77);
        chk_wr(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        settle();
    endtask

    task automatic t_dec();
        issue(OP_DEC, 1'b0, 7'h10, 8'h01);
        chk_wr(1'b0, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
        issue(OP_DEC, 1'b1, 7'h00, 8'h00);
        chk_wr(1'b1, 1'b0, 8'hff, 1'b1, 1'b0, 1'b0);
        chk("reg_addr", 16'h0000, {9'h0, reg_addr_out});
        issue(OP_DEC, 1'b0, 7'h10, 8'h80);
        chk_wr(1'b0, 1'b1, 8'h7f, 1'b1, 1'b0, 1'b0);
        settle();
    endtask

    task automatic t_decsz();
        issue(OP_DECSZ, 1'b1, 7'h41, 8'h01);
        chk_wr(1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
        chk("reg_addr", 16'h0041, {9'h0, reg_addr_out});
        chk("op_ready", 16'h0000, {15'h0, op_ready_out});
        // word still offered during the stall must be refused
        step();
        chk_wr(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        issue(OP_DECSZ, 1'b0, 7'h41, 8'h00);
        chk_wr(1'b0, 1'b1, 8'hff, 1'b0, 1'b0, 1'b0);
        chk("op_ready", 16'h0001, {15'h0, op_ready_out});
        settle();
    endtask

    initial
    begin
        failures = 0;
        n_compared = 0;
        cycles = 0;
        reset_n_in = 1'b0;
        op_valid_in = 1'b0;
        instr_in = '0;
        reg_data_in = 8'h00;
        accum_in = 8'h00;
        pc_in = 15'h0000;
        counter_latch_in = 7'h00;
        repeat (6) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        step();
        step();
        t_wdclr();
        t_call();
        t_complement_register_op();
        t_clear();
        t_dec();
        t_decsz();
        step();
        stop_test();
    end
endmodule
